// ### include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ****************************************
    // Register word indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] IDX_MAIN = 6'h00;
    localparam logic [5:0] IDX_REF = 6'h01;
    localparam logic [5:0] IDX_AVG = 6'h02;
    localparam logic [5:0] IDX_SAMP = 6'h03;
    localparam logic [5:0] IDX_CONV = 6'h04;
    localparam logic [5:0] IDX_STATUS = 6'h06;
    localparam logic [5:0] IDX_RESULT = 6'h07;

    // ****************************************
    // Field positions and writable masks
    // ****************************************
    localparam int MAIN_SOFT_RESET_REQUEST_BIT = 0;
    localparam int MAIN_ENABLE_BIT = 1;
    localparam int MAIN_STDBY_BIT = 2;
    localparam int REF_COMP_BIT = 7;
    localparam int REF_SEL_LSB = 0;
    localparam int AVG_SHIFT_LSB = 4;
    localparam int AVG_COUNT_LSB = 0;
    localparam int SAMP_LEN_LSB = 0;
    localparam int CONV_DIFF_BIT = 0;
    localparam int CONV_LEFTADJ_BIT = 1;
    localparam int CONV_FREERUN_BIT = 2;
    localparam int CONV_CORR_BIT = 3;
    localparam int CONV_RES_LSB = 4;
    localparam int CONV_PRESC_LSB = 8;
    localparam int STATUS_SYNC_BIT = 7;
    localparam logic [7:0] REF_MASK = 8'h8F;
    localparam logic [7:0] AVG_MASK = 8'h7F;
    localparam logic [7:0] SAMP_MASK = 8'h3F;
    localparam logic [15:0] CONV_MASK = 16'h073F;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_HALF = 16'h0000;
    localparam logic [3:0] ACC_MAX_CODE = 4'hA;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        RES_12BIT,
        RES_16BIT,
        RES_10BIT,
        RES_8BIT
    } resolution_type;

    typedef enum logic [3:0] {
        internal_one_volt_ref,
        supply_div_1p48_ref,
        supply_div_2_ref,
        external_ref_a,
        external_ref_b
    } reference_type;

    typedef enum {
        CONV_IDLE,
        CONV_SAMPLE,
        CONV_WAIT
    } conv_state_type;

    typedef struct packed {
        logic standby_run;
        logic enable;
        logic [7:0] ref_ctrl;
        logic [7:0] avg_ctrl;
        logic [7:0] samp_ctrl;
        logic [15:0] conv_ctrl;
    } ctrl_regs_type;

endpackage

// ### rtl/adc_control_register_bank.sv
`timescale 1ns/100ps
// Contract
// - Accept 8, 16, 32-bit atomic accesses
// - Byte and half lanes individually accessible
// - Protection controller can block writes
// - Enable-protected fields written only when disabled
// - Reserved bits read zero, written zero
// - Standby-run keeps converter alive in standby
// - Enable reads back, sync flag until applied
// - Soft reset clears registers, disables converter
// - Soft reset discards other written bits
// - Soft reset bit, sync flag clear together
// - Bit 7 switches reference offset compensation
// - Four-bit reference select, five valid codes
// - Average shift divides by two power
// - Accumulate 2^n samples, codes up to 0xA
// - Sampling lasts length plus one halves
// - Prescaler divides by 4 up to 512
// - Prescaler written only while disabled
// - Resolution selects 12, 16, 10, 8 bits
module adc_control_register_bank (
    input wire logic I_CLK, // Peripheral clock
    input wire logic I_RESET, // Synchronous reset, high
    input wire logic I_WB_CYC, // Bus cycle
    input wire logic I_WB_STB, // Bus strobe
    input wire logic I_WB_WE, // Write enable
    input wire logic [7:0] I_WB_ADR, // Byte address
    input wire logic [3:0] I_WB_SEL, // Byte lanes
    input wire logic [31:0] I_WB_DAT, // Write data
    output logic [31:0] O_WB_DAT, // Read data
    output logic O_WB_ACK, // Acknowledge
    input wire logic I_WRITE_PROTECT, // Access protection unit blocks writes
    input wire logic I_STANDBY, // Device in standby sleep
    input wire logic I_CONVERT_START, // Start one conversion
    input wire logic I_SAMPLE_VALID, // Analog core sample ready
    input wire logic [11:0] I_SAMPLE_DATA, // Analog core sample
    output logic O_CONVERTER_RUN, // Converter active
    output logic O_ADC_CLK_TICK, // Converter clock enable
    output logic O_SAMPLING, // Input sampling phase
    output logic O_CONVERT, // Waiting for analog sample
    output logic [3:0] O_REF_SELECT, // Reference choice
    output logic O_REF_COMP, // Reference offset compensation
    output logic O_DIFF_MODE, // Differential input
    output logic [15:0] O_RESULT, // Formatted result
    output logic O_RESULT_VALID // Result pulse
);

    // ****************************************
    // Functions
    // ****************************************

    // Byte lane update with writable mask
    function automatic logic [7:0] merge_byte(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask,
        input logic lane
    );
        merge_byte = lane ? (new_val & mask) : old_val;
    endfunction

    // Half-period length minus one for a prescaler code
    function automatic logic [7:0] half_limit(input logic [2:0] code);
        logic [8:0] half;
        half = 9'h002 << code;
        half_limit = 8'(half - 9'h001);
    endfunction

    // Place averaged value in the selected format
    function automatic logic [15:0] format_result(
        input logic [21:0] avg,
        input logic [1:0] res,
        input logic left
    );
        logic [15:0] val;
        val = 16'h0000;
        case (adc_ctrl_pkg::resolution_type'(res))
            adc_ctrl_pkg::RES_12BIT: val = left ? {avg[11:0], 4'h0} : {4'h0, avg[11:0]};
            adc_ctrl_pkg::RES_16BIT: val = avg[15:0];
            adc_ctrl_pkg::RES_10BIT: val = left ? {avg[11:2], 6'h00} : {6'h00, avg[11:2]};
            adc_ctrl_pkg::RES_8BIT: val = left ? {avg[11:4], 8'h00} : {8'h00, avg[11:4]};
            default: val = 16'h0000;
        endcase
        format_result = val;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    adc_ctrl_pkg::ctrl_regs_type regs, next_regs;
    logic soft_reset_request_busy, next_soft_reset_request_busy;
    logic sync_pending, next_sync_pending;
    logic sync_req, next_sync_req;
    logic conv_en, next_conv_en;
    logic [15:0] conv_sync, next_conv_sync;
    logic [7:0] div_cnt, next_div_cnt;
    logic phase, next_phase;
    adc_ctrl_pkg::conv_state_type state, next_state;
    logic [6:0] half_cnt, next_half_cnt;
    logic [10:0] sample_cnt, next_sample_cnt;
    logic [21:0] acc, next_acc;
    logic [15:0] result, next_result;
    logic result_valid, next_result_valid;
    logic [5:0] idx;
    logic wr;
    logic disabled;
    logic half_tick;
    logic full_tick;
    logic run;
    logic [3:0] acc_code;
    logic [10:0] acc_last;
    logic [21:0] sum;
    logic samp_entry;

    // ****************************************
    // Shared decode
    // ****************************************

    // Write is taken at the edge where ack is high
    assign idx = I_WB_ADR[7:2];
    assign wr = I_WB_CYC & I_WB_STB & I_WB_WE & ack & ~I_WRITE_PROTECT;
    assign disabled = ~regs.enable & ~conv_en;
    assign half_tick = (div_cnt == half_limit(regs.conv_ctrl[adc_ctrl_pkg::CONV_PRESC_LSB +: 3]));
    assign full_tick = half_tick & phase;
    assign run = conv_en & (~I_STANDBY | regs.standby_run);
    assign samp_entry = (next_state == adc_ctrl_pkg::CONV_SAMPLE)
        & (state != adc_ctrl_pkg::CONV_SAMPLE);

    // ****************************************
    // Bus slave
    // ****************************************

    // Ack one cycle after request, read data sampled with it
    always_comb begin
        next_ack = I_WB_CYC & I_WB_STB & ~ack;
        next_rdata = rdata;
        if (I_WB_CYC & I_WB_STB & ~ack) begin
            next_rdata = 32'h0000_0000;
            case (idx)
                adc_ctrl_pkg::IDX_MAIN: begin
                    next_rdata[adc_ctrl_pkg::MAIN_SOFT_RESET_REQUEST_BIT] = soft_reset_request_busy;
                    next_rdata[adc_ctrl_pkg::MAIN_ENABLE_BIT] = regs.enable;
                    next_rdata[adc_ctrl_pkg::MAIN_STDBY_BIT] = regs.standby_run;
                end
                adc_ctrl_pkg::IDX_REF: next_rdata[7:0] = regs.ref_ctrl;
                adc_ctrl_pkg::IDX_AVG: next_rdata[7:0] = regs.avg_ctrl;
                adc_ctrl_pkg::IDX_SAMP: next_rdata[7:0] = regs.samp_ctrl;
                adc_ctrl_pkg::IDX_CONV: next_rdata[15:0] = regs.conv_ctrl;
                adc_ctrl_pkg::IDX_STATUS: begin
                    next_rdata[adc_ctrl_pkg::STATUS_SYNC_BIT] = sync_pending;
                end
                adc_ctrl_pkg::IDX_RESULT: next_rdata[15:0] = result;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Register file and synchronisation
    // ****************************************

    // Completion on converter clock first, so a new write wins over a sync completion
    always_comb begin
        next_regs = regs;
        next_soft_reset_request_busy = soft_reset_request_busy;
        next_sync_pending = sync_pending;
        next_sync_req = sync_req;
        next_conv_en = conv_en;
        next_conv_sync = conv_sync;
        if (full_tick) begin
            if (soft_reset_request_busy) begin
                next_regs = '0;
                next_conv_en = 1'b0;
                next_conv_sync = adc_ctrl_pkg::RESET_HALF;
                next_soft_reset_request_busy = 1'b0;
                next_sync_pending = 1'b0;
                next_sync_req = 1'b0;
            end else if (sync_req) begin
                next_conv_en = regs.enable;
                next_conv_sync = regs.conv_ctrl;
                next_sync_req = 1'b0;
                next_sync_pending = 1'b0;
            end
        end
        if (wr & ~soft_reset_request_busy) begin
            case (idx)
                adc_ctrl_pkg::IDX_MAIN: begin
                    if (I_WB_SEL[0]) begin
                        if (I_WB_DAT[adc_ctrl_pkg::MAIN_SOFT_RESET_REQUEST_BIT]) begin
                            next_soft_reset_request_busy = 1'b1;
                            next_sync_pending = 1'b1;
                        end else begin
                            next_regs.standby_run = I_WB_DAT[adc_ctrl_pkg::MAIN_STDBY_BIT];
                            next_regs.enable = I_WB_DAT[adc_ctrl_pkg::MAIN_ENABLE_BIT];
                            next_sync_pending = 1'b1;
                            next_sync_req = 1'b1;
                        end
                    end
                end
                adc_ctrl_pkg::IDX_REF: begin
                    next_regs.ref_ctrl = merge_byte(regs.ref_ctrl, I_WB_DAT[7:0],
                        adc_ctrl_pkg::REF_MASK, I_WB_SEL[0]);
                end
                adc_ctrl_pkg::IDX_AVG: begin
                    next_regs.avg_ctrl = merge_byte(regs.avg_ctrl, I_WB_DAT[7:0],
                        adc_ctrl_pkg::AVG_MASK, I_WB_SEL[0]);
                end
                adc_ctrl_pkg::IDX_SAMP: begin
                    next_regs.samp_ctrl = merge_byte(regs.samp_ctrl, I_WB_DAT[7:0],
                        adc_ctrl_pkg::SAMP_MASK, I_WB_SEL[0]);
                end
                adc_ctrl_pkg::IDX_CONV: begin
                    if (disabled & (I_WB_SEL[0] | I_WB_SEL[1])) begin
                        next_regs.conv_ctrl[7:0] = merge_byte(regs.conv_ctrl[7:0],
                            I_WB_DAT[7:0], adc_ctrl_pkg::CONV_MASK[7:0], I_WB_SEL[0]);
                        next_regs.conv_ctrl[15:8] = merge_byte(regs.conv_ctrl[15:8],
                            I_WB_DAT[15:8], adc_ctrl_pkg::CONV_MASK[15:8], I_WB_SEL[1]);
                        next_sync_pending = 1'b1;
                        next_sync_req = 1'b1;
                    end
                end
                default: begin
                    next_regs = next_regs;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            regs <= '0;
            soft_reset_request_busy <= 1'b0;
            sync_pending <= 1'b0;
            sync_req <= 1'b0;
            conv_en <= 1'b0;
            conv_sync <= 16'h0000;
        end else begin
            regs <= next_regs;
            soft_reset_request_busy <= next_soft_reset_request_busy;
            sync_pending <= next_sync_pending;
            sync_req <= next_sync_req;
            conv_en <= next_conv_en;
            conv_sync <= next_conv_sync;
        end
    end

    // ****************************************
    // Prescaler
    // ****************************************

    // Half-period counter, restarted as sampling begins so its length is exact
    always_comb begin
        next_div_cnt = half_tick ? 8'h00 : 8'(div_cnt + 8'h01);
        next_phase = half_tick ? ~phase : phase;
        if (samp_entry) begin
            next_div_cnt = 8'h00;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            div_cnt <= 8'h00;
            phase <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            phase <= next_phase;
        end
    end

    // ****************************************
    // Conversion sequencer and averaging
    // ****************************************

    // Reserved accumulate codes act as the largest count
    always_comb begin
        acc_code = regs.avg_ctrl[adc_ctrl_pkg::AVG_COUNT_LSB +: 4];
        if (acc_code > adc_ctrl_pkg::ACC_MAX_CODE) begin
            acc_code = adc_ctrl_pkg::ACC_MAX_CODE;
        end
        acc_last = 11'((12'h001 << acc_code) - 12'h001);
        sum = acc + {10'h000, I_SAMPLE_DATA};
    end

    // Sample, wait for core, accumulate, deliver
    always_comb begin
        next_state = state;
        next_half_cnt = half_cnt;
        next_sample_cnt = sample_cnt;
        next_acc = acc;
        next_result = result;
        next_result_valid = 1'b0;
        if (~run) begin
            next_state = adc_ctrl_pkg::CONV_IDLE;
            next_sample_cnt = 11'h000;
            next_acc = 22'h00_0000;
        end else begin
            case (state)
                adc_ctrl_pkg::CONV_IDLE: begin
                    if (I_CONVERT_START) begin
                        next_state = adc_ctrl_pkg::CONV_SAMPLE;
                        next_half_cnt = 7'h00;
                    end
                end
                adc_ctrl_pkg::CONV_SAMPLE: begin
                    if (half_tick) begin
                        next_half_cnt = 7'(half_cnt + 7'h01);
                        if (half_cnt[5:0] == regs.samp_ctrl[adc_ctrl_pkg::SAMP_LEN_LSB +: 6]) begin
                            next_state = adc_ctrl_pkg::CONV_WAIT;
                        end
                    end
                end
                adc_ctrl_pkg::CONV_WAIT: begin
                    if (I_SAMPLE_VALID) begin
                        next_half_cnt = 7'h00;
                        if (sample_cnt == acc_last) begin
                            next_result = format_result(
                                sum >> regs.avg_ctrl[adc_ctrl_pkg::AVG_SHIFT_LSB +: 3],
                                conv_sync[adc_ctrl_pkg::CONV_RES_LSB +: 2],
                                conv_sync[adc_ctrl_pkg::CONV_LEFTADJ_BIT]);
                            next_result_valid = 1'b1;
                            next_acc = 22'h00_0000;
                            next_sample_cnt = 11'h000;
                            next_state = conv_sync[adc_ctrl_pkg::CONV_FREERUN_BIT]
                                ? adc_ctrl_pkg::CONV_SAMPLE : adc_ctrl_pkg::CONV_IDLE;
                        end else begin
                            next_acc = sum;
                            next_sample_cnt = 11'(sample_cnt + 11'h001);
                            next_state = adc_ctrl_pkg::CONV_SAMPLE;
                        end
                    end
                end
                default: begin
                    next_state = adc_ctrl_pkg::CONV_IDLE;
                end
            endcase
        end
        if (full_tick & soft_reset_request_busy) begin
            next_result = 16'h0000;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state <= adc_ctrl_pkg::CONV_IDLE;
            half_cnt <= 7'h00;
            sample_cnt <= 11'h000;
            acc <= 22'h00_0000;
            result <= 16'h0000;
            result_valid <= 1'b0;
        end else begin
            state <= next_state;
            half_cnt <= next_half_cnt;
            sample_cnt <= next_sample_cnt;
            acc <= next_acc;
            result <= next_result;
            result_valid <= next_result_valid;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Register-driven controls to the analog core
    assign O_WB_ACK = ack;
    assign O_WB_DAT = rdata;
    assign O_CONVERTER_RUN = run;
    assign O_ADC_CLK_TICK = full_tick;
    assign O_SAMPLING = (state == adc_ctrl_pkg::CONV_SAMPLE);
    assign O_CONVERT = (state == adc_ctrl_pkg::CONV_WAIT);
    assign O_REF_SELECT = regs.ref_ctrl[adc_ctrl_pkg::REF_SEL_LSB +: 4];
    assign O_REF_COMP = regs.ref_ctrl[adc_ctrl_pkg::REF_COMP_BIT];
    assign O_DIFF_MODE = conv_sync[adc_ctrl_pkg::CONV_DIFF_BIT];
    assign O_RESULT = result;
    assign O_RESULT_VALID = result_valid;

endmodule

// ### verification/adc_bank_props.sv
`timescale 1ns/100ps
// ****************************************
// Bus and converter timing checks
// ****************************************
module adc_bank_props (
    input wire logic I_CLK, // Clock
    input wire logic I_RESET, // Reset
    input wire logic I_WB_CYC, // Bus cycle
    input wire logic I_WB_STB, // Bus strobe
    input wire logic I_WB_WE, // Write enable
    input logic O_WB_ACK, // Acknowledge
    input logic O_CONVERTER_RUN, // Converter active
    input logic O_ADC_CLK_TICK, // Converter clock enable
    input logic O_SAMPLING, // Sampling phase
    input logic O_CONVERT, // Waiting for sample
    input logic [3:0] O_REF_SELECT, // Reference choice
    input logic O_RESULT_VALID // Result pulse
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // Bus answer timing
    property p_ack_next; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_cause; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    // Conversion phases
    property p_excl; !(O_SAMPLING && O_CONVERT); endproperty
    a_excl: assert property (p_excl) else $error("sampling and convert together");
    property p_samp_start; $rose(O_SAMPLING) |-> $past(O_CONVERTER_RUN); endproperty
    a_samp_start: assert property (p_samp_start) else $error("sampling while stopped");
    property p_samp_min; $rose(O_SAMPLING) |-> O_SAMPLING [*2]; endproperty
    a_samp_min: assert property (p_samp_min) else $error("sampling too short");
    property p_conv_after; $rose(O_CONVERT) |-> $past(O_SAMPLING); endproperty
    a_conv_after: assert property (p_conv_after) else $error("convert skipped sampling");
    property p_tick_gap; O_ADC_CLK_TICK |=> !O_ADC_CLK_TICK [*3]; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick divisor below four");
    property p_valid_pulse; O_RESULT_VALID |=> !O_RESULT_VALID; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("result pulse too long");
    property p_ref_hold;
        $changed(O_REF_SELECT) |-> $past(O_WB_ACK && I_WB_WE) || O_REF_SELECT == 4'h0;
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference changed alone");
endmodule

bind adc_control_register_bank adc_bank_props adc_bank_props_inst (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .O_WB_ACK(O_WB_ACK), .O_CONVERTER_RUN(O_CONVERTER_RUN),
    .O_ADC_CLK_TICK(O_ADC_CLK_TICK), .O_SAMPLING(O_SAMPLING), .O_CONVERT(O_CONVERT),
    .O_REF_SELECT(O_REF_SELECT), .O_RESULT_VALID(O_RESULT_VALID)
);

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
    logic clk, rst, cyc, stb, we, prot, stdby, start, sval, ack, run, tick, samp, conv;
    logic rcomp, diff, rvalid;
    logic [7:0] adr;
    logic [3:0] sel, rsel;
    logic [31:0] wdat, rdat, v;
    logic [11:0] sdat;
    logic [15:0] res;
    int mismatches, compares, n;

    adc_control_register_bank adc_control_register_bank_inst (
        .I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_WRITE_PROTECT(prot), .I_STANDBY(stdby), .I_CONVERT_START(start),
        .I_SAMPLE_VALID(sval), .I_SAMPLE_DATA(sdat), .O_CONVERTER_RUN(run),
        .O_ADC_CLK_TICK(tick), .O_SAMPLING(samp), .O_CONVERT(conv), .O_REF_SELECT(rsel),
        .O_REF_COMP(rcomp), .O_DIFF_MODE(diff), .O_RESULT(res), .O_RESULT_VALID(rvalid)
    );

    // ****************************************
    // Clock
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Report and bus tasks
    // ****************************************
    task print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task timeout(input string nm);
        mismatches++;
        $display("unexpected timeout in %s", nm);
        print_verdict();
    endtask

    // One classic cycle, held until ack is sampled
    task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) timeout("bus");
        v = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 4'hF, 32'h0);
        check(nm, v, exp);
    endtask

    // Poll status until the pending flag drops
    task wait_sync();
        int k;
        k = 0;
        do begin
            bus(1'b0, 8'h18, 4'hF, 32'h0);
            k++;
        end while (v[7] !== 1'b0 && k < 300);
        if (k >= 300) timeout("sync");
    endtask

    task automatic wait_sig(ref logic s, input string nm);
        n = 0;
        while (s !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) timeout(nm);
    endtask

    // Two samples of 0x100 and 0x300, shift one, with given low control bits
    task run_conv(input logic [7:0] r, input logic [15:0] exp);
        int c;
        bus(1'b1, 8'h00, 4'hF, 32'h0);
        wait_sync();
        bus(1'b1, 8'h10, 4'hF, {24'h0, r});
        bus(1'b1, 8'h00, 4'hF, 32'h2);
        wait_sync();
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        wait_sig(samp, "sampling");
        c = 0;
        while (samp === 1'b1 && c < 50) begin
            @(posedge clk);
            c++;
        end
        check("sampling length", 32'(c), 32'h4);
        for (int k = 0; k < 2; k++) begin
            wait_sig(conv, "convert");
            sval <= 1'b1; sdat <= (k == 0) ? 12'h100 : 12'h300;
            @(posedge clk) sval <= 1'b0;
            @(posedge clk);
        end
        wait_sig(rvalid, "result");
        check("result", {16'h0, res}, {16'h0, exp});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        wdat = 32'h0; prot = 1'b0; stdby = 1'b0; start = 1'b0; sval = 1'b0; sdat = 12'h0;
        mismatches = 0; compares = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Reset values and an unmapped place
        for (int a = 0; a < 8; a++) rd_chk(8'(a * 4), 32'h0, "reset value");
        $display("test reset done");
        // Writable fields and lanes, reserved bits written as zero
        bus(1'b1, 8'h04, 4'hF, 32'h84);
        rd_chk(8'h04, 32'h84, "reference_control");
        check("ref comp", {31'h0, rcomp}, 32'h1);
        bus(1'b1, 8'h08, 4'hF, 32'h7A);
        rd_chk(8'h08, 32'h7A, "averaging_control");
        bus(1'b1, 8'h0C, 4'hF, 32'h3F);
        rd_chk(8'h0C, 32'h3F, "sampling_time_control");
        bus(1'b1, 8'h10, 4'hF, 32'h073F);
        wait_sync();
        rd_chk(8'h10, 32'h073F, "conversion_control");
        bus(1'b1, 8'h10, 4'h1, 32'h0);
        wait_sync();
        rd_chk(8'h10, 32'h0700, "low lane only");
        prot <= 1'b1;
        bus(1'b1, 8'h04, 4'hF, 32'h0);
        rd_chk(8'h04, 32'h84, "protected write");
        prot <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, 8'h04, 4'hF, 32'(c));
            @(posedge clk);
            check("reference select", {28'h0, rsel}, 32'(c));
        end
        $display("test masks done");
        // Enable, standby and protection while enabled
        bus(1'b1, 8'h00, 4'hF, 32'h2);
        rd_chk(8'h00, 32'h2, "enable readback");
        rd_chk(8'h18, 32'h80, "sync pending");
        wait_sync();
        check("run", {31'h0, run}, 32'h1);
        stdby <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check("halted in standby", {31'h0, run}, 32'h0);
        bus(1'b1, 8'h00, 4'hF, 32'h6);
        wait_sync();
        check("run in standby", {31'h0, run}, 32'h1);
        stdby <= 1'b0;
        bus(1'b1, 8'h10, 4'hF, 32'h0);
        rd_chk(8'h10, 32'h0700, "enabled write");
        $display("test enable done");
        // Soft reset with other bits in the same write
        bus(1'b1, 8'h00, 4'hF, 32'h7);
        bus(1'b0, 8'h00, 4'hF, 32'h0);
        check("reset ongoing", {31'h0, v[0]}, 32'h1);
        wait_sync();
        rd_chk(8'h00, 32'h0, "main after reset");
        for (int a = 1; a < 5; a++) rd_chk(8'(a * 4), 32'h0, "cleared");
        check("run after reset", {31'h0, run}, 32'h0);
        $display("test soft reset done");
        // Conversions at each resolution
        bus(1'b1, 8'h08, 4'hF, 32'h11);
        bus(1'b1, 8'h0C, 4'hF, 32'h01);
        run_conv(8'h00, 16'h0200);
        run_conv(8'h10, 16'h0200);
        run_conv(8'h20, 16'h0080);
        run_conv(8'h03, 16'h2000);
        check("diff mode", {31'h0, diff}, 32'h1);
        run_conv(8'h30, 16'h0020);
        rd_chk(8'h1C, 32'h0020, "result register");
        $display("test conversion done");
        print_verdict();
    end
endmodule
